// File: card_reply_framer.sv
// Purpose: Builds card reply frames and drives them on the command line.
// Assumes: Link clock is far slower than CLK_SYS and is sampled here.
// Notes:   Reply bits change just after a falling link clock edge.
//
// How it works
// RULE_01 - Shift replies out most significant bit first.
// RULE_02 - Start and direction bits are both zero.
// RULE_03 - CRC7 protects all but conditions reply. The long reply gets no CRC7 here; it sends REG_LONG[7:1] as they stand.
// RULE_04 - Last bit of every frame is one.
// RULE_05 - Normal reply: index, status, CRC, 48 bits.
// RULE_06 - Busy variant holds DAT0 low until released.
// RULE_07 - Long reply: 136 bits, six ones check.
// RULE_08 - Long reply sends register bits 127..1.
// RULE_09 - Conditions reply: ones index, ones check.
// RULE_10 - Conditions word levels pass through unchanged.
// RULE_11 - Only four reply formats can be produced.
// RULE_12 - Error bits clear once their reply leaves.
// RULE_13 - Informational bits never block execution.
// RULE_14 - Validation errors reported now, command skipped.
// RULE_15 - Execution errors reported in next reply.
// RULE_16 - Terminated operation errors await stop/status.
// RULE_17 - Clear classes A, B and C kept.
// RULE_18 - Bit 31 flags address range faults.
// RULE_19 - Bit 30 flags block alignment faults.
// RULE_20 - Bit 29 flags block length faults.
// RULE_21 - Bit 28 flags erase order faults.
// RULE_22 - Bit 23 flags prior command CRC fault.
// RULE_23 - Bit 22 flags illegal command in state.
// RULE_24 - CRC7 over all earlier frame bits.
`timescale 1ns/10ps
module card_reply_framer
  import reply_pkg::*;
(
  // System clock and reset.
  input  wire logic         CLK_SYS,
  input  wire logic         RST_N,
  // Link clock from the host.
  input  wire logic         LINK_CLK,
  // Reply request from the command decoder.
  input  wire logic         REPLY_REQ,
  input  wire logic [1:0]   REPLY_FMT,
  input  wire logic [5:0]   REPLY_INDEX,
  input  wire logic         CMD_VALID,
  // Register contents to send.
  input  wire logic [127:0] REG_LONG,
  input  wire logic [31:0]  COND_WORD,
  input  wire logic [31:0]  INFO_BITS,
  // Validation time faults for the command now answered.
  input  wire logic         VAL_RANGE,
  input  wire logic         VAL_ALIGN,
  input  wire logic         VAL_LEN,
  input  wire logic         VAL_ERASE,
  input  wire logic         VAL_CHECK,
  input  wire logic         VAL_ILLEGAL,
  // Execution time faults and other error bits.
  input  wire logic         EXE_RANGE,
  input  wire logic         EXE_ALIGN,
  input  wire logic [31:0]  EXE_ERRORS,
  // Busy request for the busy reply variant.
  input  wire logic         BUSY_HOLD,
  // Command line drive.
  output logic              CMD_OUT,
  output logic              CMD_OE,
  // Data line 0 busy drive.
  output logic              DAT0_OUT,
  output logic              DAT0_OE,
  // Status toward the command decoder.
  output logic              REPLY_BUSY,
  output logic              REPLY_DONE,
  output logic              EXEC_SKIP,
  output logic [31:0]       STATUS_WORD
);

  // Bit count covering the longest frame.
  localparam int unsigned CNT_W = 8;

  // Sampled link clock and edge detection.
  logic             lclk_meta_ff;
  logic             lclk_sync_ff;
  logic             lclk_prev_ff;
  logic             fall_edge;

  // Frame assembly.
  logic [135:0]     frame_ff;
  logic [CNT_W-1:0] bits_left_ff;
  logic [CNT_W-1:0] crc_at_ff;
  logic [6:0]       crc_ff;
  logic             crc_on_ff;
  logic             cond_ff;
  logic             busy_fmt_ff;
  tx_state_t        state_ff;
  logic             send_last;
  logic             shift_now;
  logic             splice_now;

  // Status word storage.
  logic [31:0]      errors_ff;
  logic [31:0]      class_b_ff;
  logic [31:0]      val_word;
  logic [31:0]      b_word;
  logic             val_any;
  logic [47:0]      short_frame;
  logic [31:0]      status_now;

  // Two flip-flop synchroniser, then falling edge finder.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      lclk_meta_ff <= 1'b1;
      lclk_sync_ff <= 1'b1;
      lclk_prev_ff <= 1'b1;
    end else begin
      lclk_meta_ff <= LINK_CLK;
      lclk_sync_ff <= lclk_meta_ff;
      lclk_prev_ff <= lclk_sync_ff;
    end
  end
  assign fall_edge = lclk_prev_ff & ~lclk_sync_ff;

  // Validation faults of the command being answered.
  always_comb begin
    val_word = 32'h0000_0000;
    val_word[ADDR_RANGE_BIT]  = VAL_RANGE;                  // [RULE_18]
    val_word[BLOCK_ALIGN_BIT] = VAL_ALIGN;                  // [RULE_19]
    val_word[BLOCK_LEN_BIT]   = VAL_LEN;                    // [RULE_20]
    val_word[ERASE_ORDER_BIT] = VAL_ERASE;                  // [RULE_21]
    b_word = 32'h0000_0000;
    b_word[CHECK_FAULT_BIT]   = VAL_CHECK;                  // [RULE_22]
    b_word[ILLEGAL_BIT]       = VAL_ILLEGAL;                // [RULE_23]
  end
  // Of the class B bits only the illegal flag stops execution here; a bad CRC gets no reply.
  assign val_any = |val_word | VAL_ILLEGAL;                 // [RULE_14]

  // Status word reported now: latched errors, fresh faults, info bits.
  // Info bits only feed the word and never reach EXEC_SKIP.
  assign status_now = errors_ff | class_b_ff | val_word
                      | INFO_BITS;                          // [RULE_13]

  // Registered copy of the status word for the decoder.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      STATUS_WORD <= STATUS_RESET;
    end else begin
      STATUS_WORD <= status_now;
    end
  end

  // Normal and conditions reply layout.
  always_comb begin
    if (REPLY_FMT == FMT_COND) begin
      short_frame = {2'b00, ALL_ONES_INDEX, COND_WORD,      // [RULE_09]
                     ALL_ONES_CHECK, 1'b1};                 // [RULE_10]
    end else begin
      short_frame = {2'b00, REPLY_INDEX, status_now,        // [RULE_05]
                     7'h00, 1'b1};                          // [RULE_04]
    end
  end

  // Execution and terminated operation errors held for a later reply.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      errors_ff <= STATUS_RESET;
    end else begin
      // Clear on read once sent; a new event in that cycle still sets.
      if (send_last) begin
        errors_ff <= EXE_ERRORS;                            // [RULE_12]
      end else begin
        errors_ff <= errors_ff | EXE_ERRORS;                // [RULE_15]
      end
      if (EXE_RANGE) begin
        errors_ff[ADDR_RANGE_BIT] <= 1'b1;                  // [RULE_16]
      end
      if (EXE_ALIGN) begin
        errors_ff[BLOCK_ALIGN_BIT] <= 1'b1;                 // [RULE_16]
      end
    end
  end

  // Class B bits stay one further command, cleared by a valid command.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      class_b_ff <= STATUS_RESET;
    end else if (REPLY_REQ && state_ff == ST_IDLE) begin
      if (CMD_VALID) begin
        class_b_ff <= b_word;                               // [RULE_17]
      end else begin
        class_b_ff <= class_b_ff | b_word;
      end
    end
  end

  // Decision to skip the command after a validation fault.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      EXEC_SKIP <= 1'b0;
    end else if (REPLY_REQ && state_ff == ST_IDLE) begin
      EXEC_SKIP <= val_any;                                 // [RULE_14]
    end
  end

  // Frame loader and serial engine.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state_ff     <= ST_IDLE;
      frame_ff     <= '0;
      bits_left_ff <= '0;
      crc_at_ff    <= '0;
      crc_on_ff    <= 1'b0;
      cond_ff      <= 1'b0;
      busy_fmt_ff  <= 1'b0;
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          if (REPLY_REQ) begin
            cond_ff     <= (REPLY_FMT == FMT_COND);         // [RULE_03]
            busy_fmt_ff <= (REPLY_FMT == FMT_BUSY);
            crc_on_ff   <= (REPLY_FMT != FMT_COND);
            state_ff    <= ST_WAIT;
            // Format code picks one of the four frames only.
            if (REPLY_FMT == FMT_LONG) begin                // [RULE_11]
              frame_ff     <= {2'b00, ALL_ONES_INDEX,       // [RULE_07]
                               REG_LONG[127:1], 1'b1};      // [RULE_08]
              bits_left_ff <= CNT_W'(LONG_LEN);
              crc_at_ff    <= '0;
              crc_on_ff    <= 1'b0;
            end else begin
              frame_ff     <= {short_frame, 88'h0};         // [RULE_02]
              bits_left_ff <= CNT_W'(SHORT_LEN);
              crc_at_ff    <= CNT_W'(8);
            end
          end
        end
        ST_WAIT: begin
          // The first link fall after the take sends the start bit.
          if (fall_edge) begin
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (send_last) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
      // One bit leaves per fall; at its slot the CRC sends its top bit and the rest is spliced in.
      if (shift_now) begin
        frame_ff <= {frame_ff[134:0], 1'b0};                // [RULE_01]
        // Its low six bits take the next slots, ahead of the end bit.
        if (splice_now) begin
          frame_ff[135:130] <= crc_ff[5:0];                 // [RULE_03]
        end
        bits_left_ff <= bits_left_ff - 8'h01;
      end
    end
  end

  // A fall shifts a bit while any remain; the fall after the end bit
  // releases the line.
  assign shift_now  = (state_ff == ST_WAIT || state_ff == ST_SHIFT)
                      && fall_edge && (bits_left_ff != 8'h00);
  assign splice_now = crc_on_ff && (bits_left_ff == crc_at_ff);
  assign send_last  = (state_ff == ST_SHIFT) && fall_edge
                      && (bits_left_ff == 8'h00);

  // Running CRC7 over bits already on the line.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      crc_ff <= 7'h00;
    end else if (state_ff == ST_IDLE) begin
      crc_ff <= 7'h00;
    end else if (shift_now) begin
      crc_ff <= crc7_step(crc_ff, frame_ff[135]);           // [RULE_24]
    end
  end

  // Command line pins.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      CMD_OUT <= 1'b1;
      CMD_OE  <= 1'b0;
    end else if (shift_now) begin
      CMD_OUT <= splice_now ? crc_ff[6] : frame_ff[135];    // [RULE_03]
      CMD_OE  <= 1'b1;
    end else if (send_last) begin
      CMD_OUT <= 1'b1;
      CMD_OE  <= 1'b0;
    end
  end

  // Busy drive on data line 0 after a busy variant reply.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      DAT0_OUT <= 1'b1;
      DAT0_OE  <= 1'b0;
    end else begin
      DAT0_OUT <= 1'b0;
      if (send_last && busy_fmt_ff && BUSY_HOLD) begin
        DAT0_OE <= 1'b1;                                    // [RULE_06]
      end else if (!BUSY_HOLD) begin
        DAT0_OE <= 1'b0;
      end
    end
  end

  // Handshake flags back to the decoder.
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      REPLY_BUSY <= 1'b0;
      REPLY_DONE <= 1'b0;
    end else begin
      REPLY_DONE <= send_last;
      if (REPLY_REQ && state_ff == ST_IDLE) begin
        REPLY_BUSY <= 1'b1;
      end else if (send_last) begin
        REPLY_BUSY <= 1'b0;
      end
    end
  end

  // Frame always ends high; in normal and busy replies the CRC lands before it.
  chk_end_bit_high: assert property (                       // [RULE_04]
    @(posedge CLK_SYS) disable iff (!RST_N)
    (state_ff == ST_SHIFT && bits_left_ff == 8'h01) |-> frame_ff[135])
    else $error("Final reply bit is not one.");

  sequence load_short_s;
    state_ff == ST_IDLE && REPLY_REQ && REPLY_FMT != FMT_LONG;
  endsequence
  chk_short_start: assert property (                        // [RULE_02]
    @(posedge CLK_SYS) disable iff (!RST_N)
    load_short_s |=> frame_ff[135:134] == 2'b00
                     && bits_left_ff == 8'd48)
    else $error("Short reply loaded badly.");

  chk_cond_check: assert property (                         // [RULE_09]
    @(posedge CLK_SYS) disable iff (!RST_N)
    (state_ff == ST_IDLE && REPLY_REQ && REPLY_FMT == FMT_COND)
      |=> frame_ff[133:128] == 6'h3F && !crc_on_ff)
    else $error("Conditions reply check bits wrong.");

  chk_long_load: assert property (                          // [RULE_07]
    @(posedge CLK_SYS) disable iff (!RST_N)
    (state_ff == ST_IDLE && REPLY_REQ && REPLY_FMT == FMT_LONG)
      |=> bits_left_ff == 8'd136 && frame_ff[0]
          && frame_ff[133:128] == 6'h3F)
    else $error("Long reply loaded badly.");

  chk_error_clear: assert property (                        // [RULE_12]
    @(posedge CLK_SYS) disable iff (!RST_N)
    (send_last && EXE_ERRORS == 32'h0 && !EXE_RANGE && !EXE_ALIGN)
      |=> errors_ff == 32'h0)
    else $error("Error bits not cleared after reply.");

  chk_skip_fault: assert property (                         // [RULE_14]
    @(posedge CLK_SYS) disable iff (!RST_N)
    (state_ff == ST_IDLE && REPLY_REQ && VAL_RANGE) |=> EXEC_SKIP)
    else $error("Validation fault did not skip command.");

  chk_exec_held: assert property (                          // [RULE_15]
    @(posedge CLK_SYS) disable iff (!RST_N)
    (EXE_ERRORS[19] && !send_last) |=> ##1 STATUS_WORD[19])
    else $error("Execution error not held.");

  chk_msb_first: assert property (                          // [RULE_01]
    @(posedge CLK_SYS) disable iff (!RST_N)
    (shift_now && !splice_now)
      |=> CMD_OE && CMD_OUT == $past(frame_ff[135]))
    else $error("Reply bit order wrong.");

endmodule

// File: reply_pkg.sv
// Purpose: Shared constants for the card reply framer.
// Assumes: Status bit positions count from bit 0 of the status word.
// Notes:   Status bit positions cover the error bits this block owns.
package reply_pkg;

  // Reply frame lengths in bits.
  localparam int unsigned SHORT_LEN = 48;
  localparam int unsigned LONG_LEN  = 136;

  // Fixed check fields.
  localparam logic [5:0] ALL_ONES_INDEX = 6'h3F;
  localparam logic [6:0] ALL_ONES_CHECK = 7'h7F;

  // CRC7 generator taps, x^7 + x^3 + 1 without the x^7 term.
  localparam logic [6:0] CRC7_POLY = 7'h09;

  // Command indices with a fixed reply format.
  localparam logic [5:0] CMD_SEND_COND  = 6'h01;
  localparam logic [5:0] CMD_ALL_ID     = 6'h02;
  localparam logic [5:0] CMD_SEND_SPEC  = 6'h09;
  localparam logic [5:0] CMD_SEND_ID    = 6'h0A;

  // Status word field positions.
  localparam int unsigned ADDR_RANGE_BIT  = 31;
  localparam int unsigned BLOCK_ALIGN_BIT = 30;
  localparam int unsigned BLOCK_LEN_BIT   = 29;
  localparam int unsigned ERASE_ORDER_BIT = 28;
  localparam int unsigned CHECK_FAULT_BIT = 23;
  localparam int unsigned ILLEGAL_BIT     = 22;

  // Status word reset value.
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Reply format selector.
  typedef enum logic [1:0] {
    FMT_NORMAL,
    FMT_BUSY,
    FMT_LONG,
    FMT_COND
  } reply_fmt_t;

  // Serial engine states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_SHIFT
  } tx_state_t;

  // One CRC7 step on a single bit.
  function automatic logic [6:0] crc7_step(input logic [6:0] crc,
                                           input logic       din);
    logic fb;
    fb = crc[6] ^ din;
    crc7_step = {crc[5:0], 1'b0} ^ (fb ? CRC7_POLY : 7'h00);
  endfunction

endpackage

// File: host_link_model.sv
// Purpose: Host side of the serial link that clocks and captures replies.
// Assumes: Reply bits settle well before the next falling link edge.
// Notes:   The link clock stands high between frames.
`timescale 1ns/10ps
module host_link_model (
  // Frame control from the bench.
  input  wire logic         run,
  // Card drive of the command and data lines.
  input  wire logic         cmd_out,
  input  wire logic         cmd_oe,
  input  wire logic         dat0_out,
  input  wire logic         dat0_oe,
  // Link clock and captured reply.
  output logic              link_clk,
  output logic [135:0]      frame,
  output logic [7:0]        nbits,
  output logic              host_sees_busy
);
  logic cmd_line;

  // Released lines float to their pull-up level.
  assign cmd_line = cmd_oe ? cmd_out : 1'b1;
  assign host_sees_busy = dat0_oe & ~dat0_out;

  // Link clock runs only while a frame is wanted, off the system edges.
  initial begin
    link_clk = 1'b1;
  end
  always begin
    if (run) begin
      #200 link_clk = 1'b0;
      #200 link_clk = 1'b1;
    end else begin
      @(posedge run);
      #13;
    end
  end

  // Each falling edge takes the bit driven during the period before it.
  always @(negedge link_clk or posedge run) begin
    if (link_clk) begin
      frame = '0;
      nbits = 8'h00;
    end else if (cmd_oe) begin
      frame = {frame[134:0], cmd_line};
      nbits = nbits + 8'h01;
    end
  end
endmodule

// File: card_reply_framer_tb_top.sv
// Purpose: Self-checking bench for the card reply framer.
// Assumes: Status payload is taken when the request is accepted.
// Notes:   Expected frames and check bits are built here bit by bit.
`timescale 1ns/10ps
module card_reply_framer_tb_top;
  import reply_pkg::*;
  logic CLK_SYS, RST_N, LINK_CLK, REPLY_REQ, CMD_VALID, BUSY_HOLD;
  logic [1:0] REPLY_FMT;
  logic [5:0] REPLY_INDEX;
  logic [127:0] REG_LONG;
  logic [31:0] COND_WORD, INFO_BITS, EXE_ERRORS, STATUS_WORD;
  logic VAL_RANGE, VAL_ALIGN, VAL_LEN, VAL_ERASE, VAL_CHECK, VAL_ILLEGAL;
  logic EXE_RANGE, EXE_ALIGN, CMD_OUT, CMD_OE, DAT0_OUT, DAT0_OE;
  logic REPLY_BUSY, REPLY_DONE, EXEC_SKIP, run, busy_seen;
  logic [135:0] frame;
  logic [7:0] nbits;
  logic [31:0] exp_w, held;
  int err_count, n_checks, cyc;
  int fault_pos [6] = '{31, 30, 29, 28, 23, 22};
  localparam logic [31:0] INFO = 32'h0200_0000;

  card_reply_framer u_card_reply_framer (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
    .LINK_CLK(LINK_CLK), .REPLY_REQ(REPLY_REQ), .REPLY_FMT(REPLY_FMT),
    .REPLY_INDEX(REPLY_INDEX), .CMD_VALID(CMD_VALID), .REG_LONG(REG_LONG),
    .COND_WORD(COND_WORD), .INFO_BITS(INFO_BITS), .VAL_RANGE(VAL_RANGE),
    .VAL_ALIGN(VAL_ALIGN), .VAL_LEN(VAL_LEN), .VAL_ERASE(VAL_ERASE),
    .VAL_CHECK(VAL_CHECK), .VAL_ILLEGAL(VAL_ILLEGAL), .EXE_RANGE(EXE_RANGE),
    .EXE_ALIGN(EXE_ALIGN), .EXE_ERRORS(EXE_ERRORS), .BUSY_HOLD(BUSY_HOLD),
    .CMD_OUT(CMD_OUT), .CMD_OE(CMD_OE), .DAT0_OUT(DAT0_OUT),
    .DAT0_OE(DAT0_OE), .REPLY_BUSY(REPLY_BUSY), .REPLY_DONE(REPLY_DONE),
    .EXEC_SKIP(EXEC_SKIP), .STATUS_WORD(STATUS_WORD));

  host_link_model u_host_link_model (.run(run), .cmd_out(CMD_OUT),
    .cmd_oe(CMD_OE), .dat0_out(DAT0_OUT), .dat0_oe(DAT0_OE),
    .link_clk(LINK_CLK), .frame(frame), .nbits(nbits),
    .host_sees_busy(busy_seen));

  // System clock at 20 MHz.
  initial CLK_SYS = 1'b0;
  always #25 CLK_SYS = ~CLK_SYS;

  // Cycle ceiling cuts a hung run short.
  always @(posedge CLK_SYS) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      print_verdict();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Compares a vector result.
  task automatic chk_vec(string what, logic [135:0] exp, logic [135:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  // Compares a single flag.
  task automatic chk_bit(string what, logic exp, logic got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s exp %b got %b", what, exp, got);
    end
  endtask

  // Builds a 48-bit reply, with CRC7 over bits 47..8 when asked.
  function automatic logic [47:0] short_frame(logic [5:0] idx,
                                              logic [31:0] pay, logic crc);
    logic [47:0] f;
    logic [6:0] c;
    logic fb;
    f = {2'b00, idx, pay, 7'h7F, 1'b1};
    c = 7'h00;
    for (int i = 47; i >= 8; i--) begin
      fb = c[6] ^ f[i];
      c = {c[5:0], fb} ^ {3'b000, fb, 3'b000};
    end
    if (crc) f[7:1] = c;
    return f;
  endfunction

  // Issues one request, clocks the whole reply and checks its bits.
  task automatic reply(logic [1:0] fmt, logic [5:0] idx, logic [5:0] vf,
                       int len, logic [135:0] exp);
    int n;
    @(posedge CLK_SYS);
    REPLY_REQ <= 1'b1;
    REPLY_FMT <= fmt;
    REPLY_INDEX <= idx;
    CMD_VALID <= 1'b1;
    {VAL_RANGE, VAL_ALIGN, VAL_LEN, VAL_ERASE, VAL_CHECK, VAL_ILLEGAL} <= vf;
    @(posedge CLK_SYS);
    REPLY_REQ <= 1'b0;
    {VAL_RANGE, VAL_ALIGN, VAL_LEN, VAL_ERASE, VAL_CHECK, VAL_ILLEGAL} <= '0;
    run <= 1'b1;
    @(posedge CLK_SYS);
    chk_bit("reply busy", 1'b1, REPLY_BUSY);
    n = 0;
    while (REPLY_DONE !== 1'b1 && n < 3000) begin
      @(posedge CLK_SYS);
      n++;
    end
    run <= 1'b0;
    chk_bit("reply done", 1'b1, REPLY_DONE);
    chk_bit("busy cleared", 1'b0, REPLY_BUSY);
    chk_vec("bit count", len, nbits);
    chk_vec("frame", exp, frame);
  endtask

  // Main sequence.
  initial begin
    {RST_N, REPLY_REQ, CMD_VALID, BUSY_HOLD, EXE_RANGE, EXE_ALIGN} = '0;
    {VAL_RANGE, VAL_ALIGN, VAL_LEN, VAL_ERASE, VAL_CHECK, VAL_ILLEGAL} = '0;
    {REPLY_FMT, REPLY_INDEX, EXE_ERRORS, COND_WORD} = '0;
    REG_LONG = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3211;
    INFO_BITS = INFO;
    run = 1'b0;
    held = '0;
    repeat (4) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    reply(FMT_NORMAL, 6'h0D, 6'h00, 48, short_frame(6'h0D, INFO, 1));
    chk_bit("skip", 1'b0, EXEC_SKIP);
    // Execution faults land in the reply that follows them.
    @(posedge CLK_SYS);
    EXE_RANGE <= 1'b1;
    EXE_ALIGN <= 1'b1;
    EXE_ERRORS <= 32'h0808_0000;
    @(posedge CLK_SYS);
    {EXE_RANGE, EXE_ALIGN, EXE_ERRORS} <= '0;
    repeat (2) @(posedge CLK_SYS);
    chk_vec("status word", INFO | 32'hC808_0000, STATUS_WORD);
    reply(FMT_NORMAL, 6'h11, 6'h00, 48,
          short_frame(6'h11, INFO | 32'hC808_0000, 1));
    reply(FMT_NORMAL, 6'h0C, 6'h00, 48, short_frame(6'h0C, INFO, 1));
    // Class C faults show at once; class B ones in the next reply.
    // A bad check of the previous command does not skip this one.
    for (int k = 0; k < 6; k++) begin
      exp_w = INFO | held | ((k < 4) ? (32'h1 << fault_pos[k]) : 32'h0);
      reply(FMT_NORMAL, 6'h18, 6'h20 >> k, 48,
            short_frame(6'h18, exp_w, 1));
      chk_bit("skip", k != 4, EXEC_SKIP);
      held = (k < 4) ? 32'h0 : (32'h1 << fault_pos[k]);
    end
    reply(FMT_NORMAL, 6'h0D, 6'h00, 48, short_frame(6'h0D, INFO | held, 1));
    chk_bit("skip", 1'b0, EXEC_SKIP);
    reply(FMT_LONG, CMD_ALL_ID, 6'h00, 136,
          {2'b00, 6'h3F, REG_LONG[127:1], 1'b1});
    COND_WORD <= 32'h00FF_8000;
    reply(FMT_COND, CMD_SEND_COND, 6'h00, 48,
          short_frame(6'h3F, 32'h00FF_8000, 0));
    // Busy reply keeps DAT0 low while the card stays busy.
    BUSY_HOLD <= 1'b1;
    reply(FMT_BUSY, 6'h07, 6'h00, 48, short_frame(6'h07, INFO, 1));
    repeat (4) @(posedge CLK_SYS);
    chk_bit("busy seen", 1'b1, busy_seen);
    BUSY_HOLD <= 1'b0;
    repeat (10) @(posedge CLK_SYS);
    chk_bit("busy released", 1'b0, DAT0_OE);
    print_verdict();
  end
endmodule
